// *** verilog/pdcc_regs.sv ***
// capability and control words of a switch downstream port
// assumes one configuration access per request pulse, synchronous to clk_i
//
// Notes on behaviour
// - reserved capability bits always read zero
// - power limit scale held at zero
// - power limit value hardwired to zero
// - role based error reporting reads one
// - indicator and button flags read zero
// - long tags unsupported, bit reads zero
// - phantom functions field reads zero
// - payload supported field reads 256 bytes
// - control bit 15 reads zero
// - read request size field, reset 512 bytes
// - fetch size from limit and cache line
// - no snoop enable reads zero, ignores writes
// - control word resets to 2000h
`timescale 1ns/10ps
module pdcc_regs (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // configuration access
    input  wire logic        cfg_req_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic             cfg_hit_o,
    output logic [31:0]      cfg_rdata_o,
    // settings from elsewhere in the port
    input  wire logic [7:0]  cache_line_i,
    // fetch sizing request
    input  wire logic        fetch_req_i,
    input  wire logic [12:0] fetch_len_i,
    output logic             fetch_done_o,
    output logic [12:0]      fetch_len_o,
    // current settings
    output logic [2:0]       max_read_request_size_o,
    output logic             no_snoop_enable_o
);
    import pdcc_pkg::*;

    logic [31:0] cap_word;
    logic [15:0] ctrl_word;
    logic [2:0]  max_read_request_size_ff;
    logic [2:0]  nxt_max_read_request_size;
    logic        sel_cap;
    logic        sel_ctrl;
    logic        wr_ctrl;
    logic [2:0]  wr_code;
    logic [31:0] nxt_rdata;
    logic        ack_ff;
    logic        hit_ff;
    logic [31:0] rdata_ff;

    // capability fields
    logic [1:0]  captured_power_limit_scale;
    logic [7:0]  captured_power_limit_value;
    logic        role_based_err_report_cap;
    logic        power_indicator_flag;
    logic        attention_indicator_flag;
    logic        attention_button_flag;
    logic        long_tag_support;
    logic [1:0]  phantom_func_support;
    logic [2:0]  max_payload_supported;
    logic        no_snoop_enable;

    ////////////////////////////////////////////////////////////////////////
    // hardwired capability fields
    // the captured power limit only means something on an upstream port
    assign captured_power_limit_scale = PDCC_PLS_VAL;
    assign captured_power_limit_value = PDCC_PLV_VAL;
    assign role_based_err_report_cap  = PDCC_ROLE_BASED_ERR_REPORT_CAP_VAL;
    assign power_indicator_flag       = PDCC_PWR_IND_VAL;
    assign attention_indicator_flag   = PDCC_ATT_IND_VAL;
    assign attention_button_flag      = PDCC_ATT_BTN_VAL;
    assign long_tag_support           = PDCC_LONG_TAG_VAL;
    assign phantom_func_support       = PDCC_PHANTOM_VAL;
    assign max_payload_supported      = PDCC_MPS_VAL;

    // requests never carry the no snoop attribute
    assign no_snoop_enable            = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // capability word assembly
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[PDCC_CAP_RSVD_HI_MSB:PDCC_CAP_RSVD_HI_LSB] =
            PDCC_RSVD_HI_VAL;
        cap_word[PDCC_CAP_PLS_MSB:PDCC_CAP_PLS_LSB] =
            captured_power_limit_scale;
        cap_word[PDCC_CAP_PLV_MSB:PDCC_CAP_PLV_LSB] =
            captured_power_limit_value;
        cap_word[PDCC_CAP_RSVD_MID_MSB:PDCC_CAP_RSVD_MID_LSB] =
            PDCC_RSVD_MID_VAL;
        cap_word[PDCC_CAP_ROLE_BASED_ERR_REPORT_CAP_BIT]    = role_based_err_report_cap;
        cap_word[PDCC_CAP_PWR_IND_BIT] = power_indicator_flag;
        cap_word[PDCC_CAP_ATT_IND_BIT] = attention_indicator_flag;
        cap_word[PDCC_CAP_ATT_BTN_BIT] = attention_button_flag;
        cap_word[PDCC_CAP_RSVD_LO_MSB:PDCC_CAP_RSVD_LO_LSB] =
            PDCC_RSVD_LO_VAL;
        cap_word[PDCC_CAP_LONG_TAG_BIT] = long_tag_support;
        cap_word[PDCC_CAP_PHANTOM_MSB:PDCC_CAP_PHANTOM_LSB] =
            phantom_func_support;
        cap_word[PDCC_CAP_MPS_MSB:PDCC_CAP_MPS_LSB] =
            max_payload_supported;
    end

    ////////////////////////////////////////////////////////////////////////
    // control word assembly
    // payload size and error enables live in another block; read zero here
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[PDCC_CTL_RSVD_BIT] = 1'b0;
        ctrl_word[PDCC_CTL_MAX_READ_REQUEST_SIZE_MSB:PDCC_CTL_MAX_READ_REQUEST_SIZE_LSB] =
            max_read_request_size_ff;
        ctrl_word[PDCC_CTL_NOSNOOP_BIT] = no_snoop_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode, dword aligned; low two address bits are ignored
    always_comb begin
        sel_cap  = (cfg_addr_i[7:2] == PDCC_OFS_DEV_CAP[7:2]);
        sel_ctrl = (cfg_addr_i[7:2] == PDCC_OFS_DEV_CTRL[7:2]);
        wr_ctrl  = cfg_req_i && cfg_wr_i && sel_ctrl &&
                   cfg_be_i[PDCC_MAX_READ_REQUEST_SIZE_BYTE_LANE];
        wr_code  = cfg_wdata_i[PDCC_CTL_MAX_READ_REQUEST_SIZE_MSB:PDCC_CTL_MAX_READ_REQUEST_SIZE_LSB];
    end

    ////////////////////////////////////////////////////////////////////////
    // writable field
    // a reserved code is dropped and the old setting kept; the fetch block
    // would otherwise use the PDCC_LIMIT_TOP limit of 4096 bytes for it
    always_comb begin
        nxt_max_read_request_size = max_read_request_size_ff;
        if (wr_ctrl && (wr_code <= PDCC_MAX_READ_REQUEST_SIZE_MAX_CODE)) begin
            nxt_max_read_request_size = wr_code;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            max_read_request_size_ff <=
                PDCC_CTL_RESET[PDCC_CTL_MAX_READ_REQUEST_SIZE_MSB:PDCC_CTL_MAX_READ_REQUEST_SIZE_LSB];
        end else begin
            max_read_request_size_ff <= nxt_max_read_request_size;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data; unmapped offsets and the status half read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (sel_cap) begin
            nxt_rdata = cap_word;
        end else if (sel_ctrl) begin
            nxt_rdata = {16'h0000, ctrl_word};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer one cycle after each request, reads and writes alike
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            hit_ff <= 1'b0;
        end else begin
            ack_ff <= cfg_req_i;
            hit_ff <= cfg_req_i && (sel_cap || sel_ctrl);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (cfg_req_i && !cfg_wr_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign cfg_ack_o   = ack_ff;
    assign cfg_hit_o   = hit_ff;
    assign cfg_rdata_o = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // fetch sizing for read requests
    pdcc_fetch_size u_fetch (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .limit_code_i (max_read_request_size_ff),
        .cache_line_i (cache_line_i),
        .req_i        (fetch_req_i),
        .req_len_i    (fetch_len_i),
        .done_o       (fetch_done_o),
        .fetch_len_o  (fetch_len_o)
    );

    assign max_read_request_size_o = max_read_request_size_ff;
    assign no_snoop_enable_o       = no_snoop_enable;

endmodule // pdcc_regs

// *** common/pdcc_pkg.sv ***
// constants for the downstream port capability and control words
// assumes dword aligned configuration accesses with byte offsets
package pdcc_pkg;

    // configuration space byte offsets
    localparam logic [7:0]  PDCC_OFS_DEV_CAP       = 8'h94;
    localparam logic [7:0]  PDCC_OFS_DEV_CTRL      = 8'h98;

    // capability word field positions
    localparam int          PDCC_CAP_RSVD_HI_MSB   = 31;
    localparam int          PDCC_CAP_RSVD_HI_LSB   = 28;
    localparam int          PDCC_CAP_PLS_MSB       = 27;
    localparam int          PDCC_CAP_PLS_LSB       = 26;
    localparam int          PDCC_CAP_PLV_MSB       = 25;
    localparam int          PDCC_CAP_PLV_LSB       = 18;
    localparam int          PDCC_CAP_RSVD_MID_MSB  = 17;
    localparam int          PDCC_CAP_RSVD_MID_LSB  = 16;
    localparam int          PDCC_CAP_ROLE_BASED_ERR_REPORT_CAP_BIT      = 15;
    localparam int          PDCC_CAP_PWR_IND_BIT   = 14;
    localparam int          PDCC_CAP_ATT_IND_BIT   = 13;
    localparam int          PDCC_CAP_ATT_BTN_BIT   = 12;
    localparam int          PDCC_CAP_RSVD_LO_MSB   = 11;
    localparam int          PDCC_CAP_RSVD_LO_LSB   = 6;
    localparam int          PDCC_CAP_LONG_TAG_BIT  = 5;
    localparam int          PDCC_CAP_PHANTOM_MSB   = 4;
    localparam int          PDCC_CAP_PHANTOM_LSB   = 3;
    localparam int          PDCC_CAP_MPS_MSB       = 2;
    localparam int          PDCC_CAP_MPS_LSB       = 0;

    // capability field values
    localparam logic [3:0]  PDCC_RSVD_HI_VAL       = 4'h0;
    localparam logic [1:0]  PDCC_PLS_VAL           = 2'h0;
    localparam logic [7:0]  PDCC_PLV_VAL           = 8'h00;
    localparam logic [1:0]  PDCC_RSVD_MID_VAL      = 2'h0;
    localparam logic        PDCC_ROLE_BASED_ERR_REPORT_CAP_VAL          = 1'b1;
    localparam logic        PDCC_PWR_IND_VAL       = 1'b0;
    localparam logic        PDCC_ATT_IND_VAL       = 1'b0;
    localparam logic        PDCC_ATT_BTN_VAL       = 1'b0;
    localparam logic [5:0]  PDCC_RSVD_LO_VAL       = 6'h00;
    localparam logic        PDCC_LONG_TAG_VAL      = 1'b0;
    localparam logic [1:0]  PDCC_PHANTOM_VAL       = 2'h0;
    localparam logic [2:0]  PDCC_MPS_VAL           = 3'h1;

    // control word layout
    localparam int          PDCC_CTL_RSVD_BIT      = 15;
    localparam int          PDCC_CTL_MAX_READ_REQUEST_SIZE_MSB      = 14;
    localparam int          PDCC_CTL_MAX_READ_REQUEST_SIZE_LSB      = 12;
    localparam int          PDCC_CTL_NOSNOOP_BIT   = 11;
    localparam logic [15:0] PDCC_CTL_RESET         = 16'h2000;
    localparam logic [2:0]  PDCC_MAX_READ_REQUEST_SIZE_RESET        = 3'h2;
    localparam logic [2:0]  PDCC_MAX_READ_REQUEST_SIZE_MAX_CODE     = 3'h5;
    localparam int          PDCC_MAX_READ_REQUEST_SIZE_BYTE_LANE    = 1;

    // fetch sizing
    localparam logic [12:0] PDCC_LIMIT_BASE        = 13'h0080;
    localparam logic [12:0] PDCC_LIMIT_TOP         = 13'h1000;

endpackage

// *** verilog/pdcc_fetch_size.sv ***
// fetch length decision for outgoing read requests
// assumes the limit code is already legal and the cache line is in dwords
`timescale 1ns/10ps
module pdcc_fetch_size (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // settings
    input  wire logic [2:0]  limit_code_i,
    input  wire logic [7:0]  cache_line_i,
    // request
    input  wire logic        req_i,
    input  wire logic [12:0] req_len_i,
    // answer
    output logic             done_o,
    output logic [12:0]      fetch_len_o
);
    import pdcc_pkg::*;

    logic [12:0] limit_bytes;
    logic [13:0] line_bytes;
    logic        line_pow2;
    logic [13:0] rounded;
    logic [13:0] wanted;
    logic [12:0] nxt_fetch_len;
    logic        done_ff;
    logic [12:0] fetch_len_ff;

    ////////////////////////////////////////////////////////////////////////
    // limit from the programmed code
    always_comb begin
        if (limit_code_i > PDCC_MAX_READ_REQUEST_SIZE_MAX_CODE) begin
            limit_bytes = PDCC_LIMIT_TOP;
        end else begin
            limit_bytes = PDCC_LIMIT_BASE << limit_code_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // widen to a whole cache line, then clip to the limit
    // a non power of two line size cannot be aligned, so it is not used
    always_comb begin
        line_bytes = {4'h0, cache_line_i, 2'b00};
        line_pow2  = (line_bytes != 14'h0000) &&
                     ((line_bytes & (line_bytes - 14'h0001)) == 14'h0000);
        rounded    = ({1'b0, req_len_i} + line_bytes - 14'h0001) &
                     ~(line_bytes - 14'h0001);
        wanted     = line_pow2 ? rounded : {1'b0, req_len_i};
        if (wanted > {1'b0, limit_bytes}) begin
            nxt_fetch_len = limit_bytes;
        end else begin
            nxt_fetch_len = wanted[12:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= req_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_len_ff <= 13'h0000;
        end else if (req_i) begin
            fetch_len_ff <= nxt_fetch_len;
        end
    end

    assign done_o      = done_ff;
    assign fetch_len_o = fetch_len_ff;

endmodule // pdcc_fetch_size

// *** dv/pdcc_checker.sv ***
// assertions on the capability and control word port
// bound onto pdcc_regs from the testbench top file
`timescale 1ns/10ps
module pdcc_checker (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // configuration access
    input wire logic        cfg_req_i,
    input wire logic        cfg_wr_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [3:0]  cfg_be_i,
    input wire logic [31:0] cfg_rdata_o,
    // fetch and settings
    input wire logic        fetch_req_i,
    input wire logic        fetch_done_o,
    input wire logic [12:0] fetch_len_o,
    input wire logic [2:0]  max_read_request_size_o,
    input wire logic        no_snoop_enable_o
);
    logic        rd_cap;
    logic        rd_ctl;
    logic        wr_ctl;
    logic [31:0] q;
    logic [2:0]  sz;
    assign rd_cap = cfg_req_i && !cfg_wr_i && cfg_addr_i[7:2] == 6'h25;
    assign rd_ctl = cfg_req_i && !cfg_wr_i && cfg_addr_i[7:2] == 6'h26;
    assign wr_ctl = cfg_req_i && cfg_wr_i && cfg_addr_i[7:2] == 6'h26;
    assign q = cfg_rdata_o;
    assign sz = max_read_request_size_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    a_cap_rsvd_zero: assert property (rd_cap |=>
        q[31:28] == 4'h0 && q[17:16] == 2'h0 && q[11:6] == 6'h00)
        else $error("cap reserved bits set");
    a_pwr_scale_zero: assert property (rd_cap |=> q[27:26] == 2'h0)
        else $error("power scale not zero");
    a_pwr_value_zero: assert property (rd_cap |=> q[25:18] == 8'h00)
        else $error("power value not zero");
    a_role_err_one: assert property (rd_cap |=> q[15])
        else $error("role error bit clear");
    a_ind_flags_zero: assert property (rd_cap |=> q[14:12] == 3'h0)
        else $error("indicator flags set");
    a_payload_cap: assert property (rd_cap |=> q[5:0] == 6'h01)
        else $error("payload or tag fields wrong");
    a_ctl_rsvd_zero: assert property (rd_ctl |=> !q[15])
        else $error("control bit 15 set");
    a_no_snoop_zero: assert property (rd_ctl |=>
        !q[11] && !no_snoop_enable_o)
        else $error("no snoop enable set");
    a_size_readback: assert property (rd_ctl |=> q[14:12] == $past(sz))
        else $error("size field readback wrong");
    a_size_legal: assert property (sz <= 3'h5)
        else $error("size code reserved");
    a_size_reset: assert property ($past(rst_i) |-> sz == 3'h2)
        else $error("size code reset wrong");
    a_size_hold: assert property (!(wr_ctl && cfg_be_i[1]) |=>
        $stable(sz))
        else $error("size changed without write");
    a_fetch_limit: assert property (fetch_req_i |=> fetch_done_o &&
        fetch_len_o <= (13'h0080 << $past(sz)))
        else $error("fetch over limit or late");
endmodule // pdcc_checker

// *** dv/pdcc_host.sv ***
// host configuration software issuing single dword accesses
// assumes the one cycle registered answer of the register port
`timescale 1ns/10ps
module pdcc_host (
    // clock
    input  wire logic        clk_i,
    // request
    output logic             cfg_req_o,
    output logic             cfg_wr_o,
    output logic [7:0]       cfg_addr_o,
    output logic [3:0]       cfg_be_o,
    output logic [31:0]      cfg_wdata_o,
    // answer
    input  wire logic        cfg_ack_i,
    input  wire logic [31:0] cfg_rdata_i
);
    initial begin
        cfg_req_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_addr_o = 8'h00;
        cfg_be_o = 4'h0;
        cfg_wdata_o = 32'h0;
    end
    // q stays unknown when no answer comes, so a hang shows as mismatch
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
        q = 'x;
        @(posedge clk_i);
        cfg_req_o <= 1'b1;
        cfg_wr_o <= w;
        cfg_addr_o <= a;
        cfg_be_o <= be;
        cfg_wdata_o <= d;
        @(posedge clk_i);
        cfg_req_o <= 1'b0;
        // released address and data lines toggle so stale values are never trusted
        cfg_addr_o <= ~a;
        cfg_wdata_o <= ~d;
        for (int n = 0; n < 4; n++) begin
            @(posedge clk_i);
            if (cfg_ack_i === 1'b1) begin
                q = cfg_rdata_i;
                break;
            end
        end
    endtask
endmodule // pdcc_host

// *** dv/test_pdcc_regs.sv ***
// self-checking bench for the capability and control register port
// assumes the host model and checker files are compiled first
`timescale 1ns/10ps
module test_pdcc_regs;
    import pdcc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req, wr, ack, hit, fdone, nse;
    logic [7:0]  addr;
    logic [7:0]  cache_line_i = 8'h00;
    logic [3:0]  be;
    logic [31:0] wdata, rdata, q;
    logic        fetch_req_i = 1'b0;
    logic [12:0] fetch_len_i = 13'h0;
    logic [12:0] flen, g;
    logic [2:0]  size;
    logic [3:0]  c;
    int          n_fail = 0;
    int          n_checks = 0;
    always #12.5 clk_i = ~clk_i;
    pdcc_host host (.clk_i(clk_i), .cfg_req_o(req), .cfg_wr_o(wr),
        .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata),
        .cfg_ack_i(ack), .cfg_rdata_i(rdata));
    pdcc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cfg_req_i(req),
        .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wdata), .cfg_ack_o(ack), .cfg_hit_o(hit),
        .cfg_rdata_o(rdata), .cache_line_i(cache_line_i),
        .fetch_req_i(fetch_req_i), .fetch_len_i(fetch_len_i),
        .fetch_done_o(fdone), .fetch_len_o(flen),
        .max_read_request_size_o(size), .no_snoop_enable_o(nse));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d);
        logic [31:0] x;
        host.xfer(1'b1, a, b, d, x);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
        host.xfer(1'b0, a, 4'hf, 32'h0, r);
    endtask
    // done is a one cycle pulse, so it is read at the edge that ends it
    task automatic fetch(input logic [12:0] len, input logic [7:0] cls,
        output logic [12:0] got);
        @(posedge clk_i);
        fetch_req_i <= 1'b1;
        fetch_len_i <= len;
        cache_line_i <= cls;
        @(posedge clk_i);
        fetch_req_i <= 1'b0;
        @(posedge clk_i);
        got = (fdone === 1'b1) ? flen : 13'hx;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_reg(PDCC_OFS_DEV_CTRL, q);
        check("ctl_reset", q, 32'h00002000);
        rd_reg(PDCC_OFS_DEV_CAP, q);
        check("cap_word", q, 32'h00008001);
        check("hit_cap", {31'h0, hit}, 32'h1);
        check("cap_low", {26'h0, q[5:0]}, 32'h01);
        wr_reg(PDCC_OFS_DEV_CAP, 4'hf, 32'hffffffff);
        rd_reg(PDCC_OFS_DEV_CAP, q);
        check("cap_after_wr", q, 32'h00008001);
        for (c = 4'h0; c < 4'h6; c++) begin
            wr_reg(PDCC_OFS_DEV_CTRL, 4'hf, 32'hffff8fff | (c << 12));
            rd_reg(PDCC_OFS_DEV_CTRL, q);
            check("ctl_code", q, {17'h0, c[2:0], 12'h000});
            check("size_o", {29'h0, size}, {29'h0, c[2:0]});
            fetch(13'h1fff, 8'h00, g);
            check("fetch_top", {19'h0, g}, 32'h80 << c);
        end
        for (c = 4'h6; c < 4'h8; c++) begin
            wr_reg(PDCC_OFS_DEV_CTRL, 4'hf, {20'h0, c[2:0], 12'h0});
            rd_reg(PDCC_OFS_DEV_CTRL, q);
            check("rsvd_code", q, 32'h00005000);
        end
        wr_reg(PDCC_OFS_DEV_CTRL, 4'hd, 32'h0);
        wr_reg(8'h9c, 4'hf, 32'h0);
        check("hit_other", {31'h0, hit}, 32'h0);
        rd_reg(PDCC_OFS_DEV_CTRL, q);
        check("ctl_kept", q, 32'h00005000);
        wr_reg(PDCC_OFS_DEV_CTRL, 4'h2, 32'h00002800);
        fetch(13'd100, 8'd16, g);
        check("fetch_round", {19'h0, g}, 32'd128);
        fetch(13'd600, 8'd16, g);
        check("fetch_clip", {19'h0, g}, 32'd512);
        fetch(13'd100, 8'd12, g);
        check("fetch_plain", {19'h0, g}, 32'd100);
        rd_reg(PDCC_OFS_DEV_CTRL, q);
        check("nosnoop_wr", q, 32'h00002000);
        check("nse_o", {31'h0, nse}, 32'h0);
        wr_reg(PDCC_OFS_DEV_CTRL, 4'hf, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_reg(PDCC_OFS_DEV_CTRL, q);
        check("ctl_rereset", q, 32'h00002000);
        summarize();
    end
    initial begin
        repeat (2000) @(posedge clk_i);
        n_fail++;
        summarize();
    end
endmodule // test_pdcc_regs
bind pdcc_regs pdcc_checker chk (.clk_i(clk_i), .rst_i(rst_i),
    .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i), .cfg_rdata_o(cfg_rdata_o),
    .fetch_req_i(fetch_req_i), .fetch_done_o(fetch_done_o),
    .fetch_len_o(fetch_len_o),
    .max_read_request_size_o(max_read_request_size_o),
    .no_snoop_enable_o(no_snoop_enable_o));
